//--- rtl/usb_misc_pkg.sv
package usb_misc_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0]  FRAME_NUMBER_OFS     = 8'h74;
    localparam logic [7:0]  FIRMWARE_SCRATCH_OFS = 8'h78;
    localparam logic [7:0]  WRITE_UNLOCK_KEY_OFS = 8'h7c;
    localparam logic [7:0]  LINE_TEST_MODE_OFS   = 8'h84;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int          FRAME_COUNT_LSB      = 0;
    localparam int          FRAME_COUNT_MSB      = 10;
    localparam int          MICROFRAME_LSB       = 11;
    localparam int          MICROFRAME_MSB       = 13;
    localparam int          FORCE_HS_BIT         = 7;
    localparam int          FORCE_FS_BIT         = 4;
    localparam int          RANDOM_PATTERN_BIT   = 3;
    localparam int          DRIVE_K_BIT          = 2;
    localparam int          DRIVE_J_BIT          = 1;
    localparam int          QUIESCENT_NAK_BIT    = 0;
    localparam logic [7:0]  TEST_WRITABLE_MASK   = 8'h9f;
    localparam logic [7:0]  TEST_SPEED_MASK      = 8'h90;
    localparam logic [7:0]  TEST_PATTERN_MASK    = 8'h0f;

    // ****************************************
    // Values and reset values
    // ****************************************
    localparam logic [15:0] UNLOCK_KEY_VALUE     = 16'haa37;
    localparam logic [10:0] FRAME_COUNT_RESET    = 11'h000;
    localparam logic [2:0]  MICROFRAME_RESET     = 3'h0;
    localparam logic [15:0] SCRATCH_RESET        = 16'h0000;
    localparam logic [7:0]  TEST_MODE_RESET      = 8'h00;
    localparam logic [14:0] PATTERN_SEED         = 15'h7fff;
    localparam logic [15:0] READ_IDLE_VALUE      = 16'h0000;

    typedef enum logic {
        byte_low,
        byte_high
    } byte_phase_t;

endpackage : usb_misc_pkg

//--- rtl/usb_misc_regs.sv
// How it works
// [R1] Last error-free start-of-frame number is latched into read-only register 74h.
// [R2] Byte-wide reads of the frame register give low byte, then high byte.
// [R3] Microframe index sits in bits 13:11, frame count in bits 10:0.
// [R4] Microframe and frame count clear on chip reset and on bus reset.
// [R5] Scratch register at 78h, read/write, cleared on chip and bus reset.
// [R6] With host power flag low, suspend entry blocks every register write except to 7Ch.
// [R7] Writing key AA37h to register 7Ch lifts the write block.
// [R8] Host must send the key before other writes after such a resume.
// [R9] With host power flag high, suspend never blocks writes.
// [R10] Unlock register is write-only and holds no reset value.
// [R11] Test bit 7 forces high-speed only and turns chirp detection off.
// [R12] Test bit 4 forces full-speed only and turns chirp detection off.
// [R13] Test bit 3 drives a fixed pseudo-random toggle on the data lines.
// [R14] Test bit 2 holds the lines in K, bit 1 in J.
// [R15] Test bit 0 holds lines quiescent; only high-speed IN answered with NAK.
// [R16] Firmware sets at most one speed bit and one pattern bit.
// [R17] Once a test mode is entered only power removal leaves it; here chip reset clears all test bits and bus reset the pattern bits.
// [R18] Chip reset clears all test bits; bus reset clears only pattern bits.
// [R19] Reserved bits of frame and test registers read zero, ignore writes.
`timescale 1ns/10ps

module usb_misc_regs (
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Host port, same clock as the block
    input  wire logic        host_select,
    input  wire logic        host_read,
    input  wire logic        host_write,
    input  wire logic [7:0]  host_address,
    input  wire logic [15:0] host_wdata,
    input  wire logic        host_byte_mode,
    output logic      [15:0] host_rdata,
    output logic             host_rvalid,
    // USB core events
    input  wire logic        sof_ok,
    input  wire logic [10:0] sof_frame,
    input  wire logic [2:0]  sof_microframe,
    input  wire logic        usb_bus_reset,
    input  wire logic        suspend,
    input  wire logic        host_powered_flag,
    // Controls towards the rest of the chip
    output logic             write_locked,
    output logic             force_high_speed,
    output logic             force_full_speed,
    output logic             chirp_disable,
    output logic             random_pattern_test,
    output logic             drive_k_level,
    output logic             drive_j_level,
    output logic             quiescent_nak_test,
    output logic             test_mode_active,
    output logic             line_oe,
    output logic             line_dp,
    output logic             line_dm
);

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic is_wide(input logic [7:0] addr);
        is_wide = (addr == usb_misc_pkg::FRAME_NUMBER_OFS)
               || (addr == usb_misc_pkg::FIRMWARE_SCRATCH_OFS)
               || (addr == usb_misc_pkg::WRITE_UNLOCK_KEY_OFS);
    endfunction : is_wide

    logic                      rd_req;
    logic                      wr_req;
    logic                      wr_ok;
    logic                      byte_step;
    logic                      second_byte;
    logic                      key_ok;
    logic                      suspend_entry;
    logic [15:0]               frame_word;
    logic [7:0]                test_d;

    usb_misc_pkg::byte_phase_t phase_q;
    logic [7:0]                phase_addr_q;
    logic [10:0]               frame_count_field_q;
    logic [2:0]                microframe_index_q;
    logic [7:0]                frame_high_hold_q;
    logic [7:0]                scratch_high_byte_q;
    logic [7:0]                scratch_low_byte_q;
    logic [7:0]                unlock_low_q;
    logic                      suspend_q;
    logic                      locked_q;
    logic [7:0]                test_q;
    logic                      chirp_q;
    logic                      active_q;
    logic [14:0]               lfsr_q;
    logic                      oe_q;
    logic                      dp_q;
    logic                      dm_q;
    logic [15:0]               rdata_q;
    logic                      rvalid_q;

    assign rd_req        = host_select & host_read;
    assign wr_req        = host_select & host_write;
    assign byte_step     = host_byte_mode & is_wide(host_address);
    assign second_byte   = byte_step && (phase_q == usb_misc_pkg::byte_high)
                           && (phase_addr_q == host_address);
    assign suspend_entry = suspend & ~suspend_q;

    // [R3] Field packing
    assign frame_word    = {2'b00, microframe_index_q, frame_count_field_q};

    // ****************************************
    // Byte-wide access sequencing
    // ****************************************
    // Pointer restarts on any other address so a stray access cannot skew pairing
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_q      <= usb_misc_pkg::byte_low;
            phase_addr_q <= 8'h00;
        end else if (rd_req || wr_req) begin
            phase_addr_q <= host_address;
            if (byte_step && !second_byte) begin
                phase_q <= usb_misc_pkg::byte_high;
            end else begin
                phase_q <= usb_misc_pkg::byte_low;
            end
        end
    end

    // ****************************************
    // Frame number capture
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // [R4] Chip reset clear
            frame_count_field_q <= usb_misc_pkg::FRAME_COUNT_RESET;
            microframe_index_q  <= usb_misc_pkg::MICROFRAME_RESET;
        end else if (usb_bus_reset) begin
            // [R4] Bus reset clear
            frame_count_field_q <= usb_misc_pkg::FRAME_COUNT_RESET;
            microframe_index_q  <= usb_misc_pkg::MICROFRAME_RESET;
        end else if (sof_ok) begin
            // [R1] Latch good SOF
            frame_count_field_q <= sof_frame;
            microframe_index_q  <= sof_microframe;
        end
    end

    // High byte is frozen at the low-byte read so a SOF in between cannot tear the pair
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            frame_high_hold_q <= 8'h00;
        end else if (rd_req && byte_step && !second_byte
                     && host_address == usb_misc_pkg::FRAME_NUMBER_OFS) begin
            // [R2] Snapshot upper half
            frame_high_hold_q <= frame_word[15:8];
        end
    end

    // ****************************************
    // Write lock across suspend
    // ****************************************
    // [R7] Key match in either width
    assign key_ok = host_select && host_write
                    && host_address == usb_misc_pkg::WRITE_UNLOCK_KEY_OFS
                    && (host_byte_mode
                        ? (second_byte && {host_wdata[7:0], unlock_low_q}
                                          == usb_misc_pkg::UNLOCK_KEY_VALUE)
                        : host_wdata == usb_misc_pkg::UNLOCK_KEY_VALUE);

    // [R6] Gate writes while locked; unlock register stays reachable
    // [R8] Host sends the key first, other writes meanwhile are dropped
    assign wr_ok = wr_req
                   && (!locked_q || host_address == usb_misc_pkg::WRITE_UNLOCK_KEY_OFS);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            suspend_q <= 1'b0;
        end else begin
            suspend_q <= suspend;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            locked_q <= 1'b0;
        end else if (suspend_entry && !host_powered_flag) begin
            // [R6] Lock on suspend entry; wins over a key in the same cycle
            locked_q <= 1'b1;
        end else if (key_ok) begin
            // [R7] Key lifts the lock
            locked_q <= 1'b0;
        end
        // [R9] Host-powered suspend leaves the lock alone
    end

    // [R10] Key register is write-only; only a half-key staging byte is kept
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            unlock_low_q <= 8'h00;
        end else if (wr_req && byte_step && !second_byte
                     && host_address == usb_misc_pkg::WRITE_UNLOCK_KEY_OFS) begin
            unlock_low_q <= host_wdata[7:0];
        end
    end

    // ****************************************
    // Firmware scratch
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // [R5] Chip reset clear
            scratch_high_byte_q <= usb_misc_pkg::SCRATCH_RESET[15:8];
            scratch_low_byte_q  <= usb_misc_pkg::SCRATCH_RESET[7:0];
        end else if (usb_bus_reset) begin
            // [R5] Bus reset clear
            scratch_high_byte_q <= usb_misc_pkg::SCRATCH_RESET[15:8];
            scratch_low_byte_q  <= usb_misc_pkg::SCRATCH_RESET[7:0];
        end else if (wr_ok && host_address == usb_misc_pkg::FIRMWARE_SCRATCH_OFS) begin
            // [R5] Byte or word store
            if (!host_byte_mode) begin
                scratch_high_byte_q <= host_wdata[15:8];
                scratch_low_byte_q  <= host_wdata[7:0];
            end else if (second_byte) begin
                scratch_high_byte_q <= host_wdata[7:0];
            end else begin
                scratch_low_byte_q  <= host_wdata[7:0];
            end
        end
    end

    // ****************************************
    // Line test mode
    // ****************************************
    always_comb begin
        test_d = test_q;
        if (usb_bus_reset) begin
            // [R18] Speed bits survive bus reset
            test_d = test_q & usb_misc_pkg::TEST_SPEED_MASK;
        end else if (wr_ok && host_address == usb_misc_pkg::LINE_TEST_MODE_OFS) begin
            // [R17] Bits only accumulate; software cannot clear them
            // [R19] Reserved bits masked off
            test_d = test_q | (host_wdata[7:0] & usb_misc_pkg::TEST_WRITABLE_MASK);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // [R18] Chip reset clears all
            test_q  <= usb_misc_pkg::TEST_MODE_RESET;
            chirp_q <= 1'b0;
        end else begin
            test_q  <= test_d;
            // [R11] [R12] Either forced speed turns off chirp detection
            chirp_q <= test_d[usb_misc_pkg::FORCE_HS_BIT] | test_d[usb_misc_pkg::FORCE_FS_BIT];
        end
    end

    // [R17] Sticky test indication, only a chip reset clears it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else if (|test_d) begin
            active_q <= 1'b1;
        end
    end

    // [R13] 15-bit LFSR, steps only while test bit 3 is set, taps 15 and 14
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lfsr_q <= usb_misc_pkg::PATTERN_SEED;
        end else if (test_q[usb_misc_pkg::RANDOM_PATTERN_BIT]) begin
            lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
        end
    end

    // Firmware is trusted to set one pattern bit; the order here only breaks ties
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
            dp_q <= 1'b0;
            dm_q <= 1'b0;
        end else if (test_q[usb_misc_pkg::RANDOM_PATTERN_BIT]) begin
            // [R13] Pseudo-random toggle
            oe_q <= 1'b1;
            dp_q <= lfsr_q[14];
            dm_q <= ~lfsr_q[14];
        end else if (test_q[usb_misc_pkg::DRIVE_K_BIT]) begin
            // [R14] K state
            oe_q <= 1'b1;
            dp_q <= 1'b0;
            dm_q <= 1'b1;
        end else if (test_q[usb_misc_pkg::DRIVE_J_BIT]) begin
            // [R14] J state
            oe_q <= 1'b1;
            dp_q <= 1'b1;
            dm_q <= 1'b0;
        end else if (test_q[usb_misc_pkg::QUIESCENT_NAK_BIT]) begin
            // [R15] Quiescent lines
            oe_q <= 1'b1;
            dp_q <= 1'b0;
            dm_q <= 1'b0;
        end else begin
            oe_q <= 1'b0;
            dp_q <= 1'b0;
            dm_q <= 1'b0;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_q  <= usb_misc_pkg::READ_IDLE_VALUE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_req;
            rdata_q  <= usb_misc_pkg::READ_IDLE_VALUE;
            if (rd_req) begin
                case (host_address)
                    usb_misc_pkg::FRAME_NUMBER_OFS: begin
                        // [R2] Low byte first, held high byte second
                        if (!host_byte_mode) begin
                            rdata_q <= frame_word;
                        end else if (second_byte) begin
                            rdata_q <= {8'h00, frame_high_hold_q};
                        end else begin
                            rdata_q <= {8'h00, frame_word[7:0]};
                        end
                    end
                    usb_misc_pkg::FIRMWARE_SCRATCH_OFS: begin
                        if (!host_byte_mode) begin
                            rdata_q <= {scratch_high_byte_q, scratch_low_byte_q};
                        end else if (second_byte) begin
                            rdata_q <= {8'h00, scratch_high_byte_q};
                        end else begin
                            rdata_q <= {8'h00, scratch_low_byte_q};
                        end
                    end
                    usb_misc_pkg::LINE_TEST_MODE_OFS: begin
                        // [R19] Reserved bits read zero
                        rdata_q <= {8'h00, test_q & usb_misc_pkg::TEST_WRITABLE_MASK};
                    end
                    default: begin
                        // [R10] Unlock and unmapped read as zero
                        rdata_q <= usb_misc_pkg::READ_IDLE_VALUE;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign host_rdata          = rdata_q;
    assign host_rvalid         = rvalid_q;
    assign write_locked        = locked_q;
    // [R11] Force high-speed
    assign force_high_speed    = test_q[usb_misc_pkg::FORCE_HS_BIT];
    // [R12] Force full-speed
    assign force_full_speed    = test_q[usb_misc_pkg::FORCE_FS_BIT];
    assign chirp_disable       = chirp_q;
    assign random_pattern_test = test_q[usb_misc_pkg::RANDOM_PATTERN_BIT];
    assign drive_k_level       = test_q[usb_misc_pkg::DRIVE_K_BIT];
    assign drive_j_level       = test_q[usb_misc_pkg::DRIVE_J_BIT];
    // [R15] Tells the packet engine to NAK high-speed IN only
    assign quiescent_nak_test  = test_q[usb_misc_pkg::QUIESCENT_NAK_BIT];
    assign test_mode_active    = active_q;
    assign line_oe             = oe_q;
    assign line_dp             = dp_q;
    assign line_dm             = dm_q;

endmodule : usb_misc_regs

//--- tb/usb_misc_assertions.sv
`timescale 1ns/10ps

module usb_misc_assertions (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        host_select,
    input wire logic        host_read,
    input wire logic        host_write,
    input wire logic [7:0]  host_address,
    input wire logic [15:0] host_wdata,
    input wire logic        host_byte_mode,
    input wire logic [15:0] host_rdata,
    input wire logic        host_rvalid,
    input wire logic        sof_ok,
    input wire logic        usb_bus_reset,
    input wire logic        suspend,
    input wire logic        host_powered_flag,
    input wire logic        write_locked,
    input wire logic        force_high_speed,
    input wire logic        force_full_speed,
    input wire logic        chirp_disable,
    input wire logic        random_pattern_test,
    input wire logic        drive_k_level,
    input wire logic        drive_j_level,
    input wire logic        quiescent_nak_test,
    input wire logic        test_mode_active,
    input wire logic        line_oe,
    input wire logic        line_dp,
    input wire logic        line_dm
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic rd74;
    logic wr_key;
    logic any_pat;
    assign rd74 = host_select && host_read && !host_byte_mode && host_address == usb_misc_pkg::FRAME_NUMBER_OFS;
    assign wr_key = host_select && host_write && !host_byte_mode && host_address == usb_misc_pkg::WRITE_UNLOCK_KEY_OFS
                    && host_wdata == usb_misc_pkg::UNLOCK_KEY_VALUE;
    assign any_pat = random_pattern_test || drive_k_level || drive_j_level || quiescent_nak_test;

    sequence bus_clear_s;
        usb_bus_reset && !sof_ok ##1 !sof_ok;
    endsequence
    sequence word_read_s;
        rd74 && !sof_ok && !usb_bus_reset;
    endsequence

    read_answer_a: assert property (host_select && host_read |=> host_rvalid)
        else $error("read gave no valid pulse");
    frame_clear_a: assert property (bus_clear_s ##1 word_read_s |=> host_rdata == 16'h0000)
        else $error("frame number not cleared by bus reset");
    frame_reserved_a: assert property (rd74 |=> host_rdata[15:14] == 2'h0)
        else $error("frame reserved bits not zero");
    key_unreadable_a: assert property (host_select && host_read && host_address == 8'h7c |=> host_rdata == 16'h0000)
        else $error("unlock register readable");
    lock_entry_a: assert property ($rose(suspend) && !host_powered_flag |=> write_locked)
        else $error("suspend did not lock writes");
    no_lock_a: assert property ($rose(suspend) && host_powered_flag && !write_locked |=> !write_locked)
        else $error("powered host locked on suspend");
    key_unlock_a: assert property (wr_key && !($rose(suspend) && !host_powered_flag) |=> !write_locked)
        else $error("key did not unlock");
    chirp_off_a: assert property (chirp_disable == (force_high_speed || force_full_speed))
        else $error("chirp disable mismatch");
    mode_sticky_a: assert property (test_mode_active |=> test_mode_active)
        else $error("test mode left without chip reset");
    pattern_clear_a: assert property (usb_bus_reset |=> !any_pat && $stable({force_high_speed, force_full_speed}))
        else $error("bus reset handling of test bits wrong");
    k_line_a: assert property (drive_k_level && !random_pattern_test |=> line_oe && !line_dp && line_dm)
        else $error("lines not in K");
endmodule : usb_misc_assertions

bind usb_misc_regs usb_misc_assertions chk (.*);

//--- tb/host_model.sv
`timescale 1ns/10ps

module host_model (
    input  wire logic        clock,
    input  wire logic [15:0] host_rdata,
    input  wire logic        host_rvalid,
    output logic             host_select,
    output logic             host_read,
    output logic             host_write,
    output logic [7:0]       host_address,
    output logic [15:0]      host_wdata,
    output logic             host_byte_mode
);
    // ****************************************
    // Host bus cycles
    // ****************************************
    initial begin
        {host_select, host_read, host_write, host_byte_mode} = 4'h0;
        {host_address, host_wdata} = 24'h000000;
    end

    // Strobes are one-cycle pulses: holding them would issue a second access
    task automatic access(input logic [7:0] a, input logic [15:0] d, input logic w, input logic b);
        @(posedge clock);
        host_select <= 1'b1;
        host_read <= !w;
        host_write <= w;
        host_address <= a;
        host_wdata <= d;
        host_byte_mode <= b;
        @(posedge clock);
        host_select <= 1'b0;
        host_read <= 1'b0;
        host_write <= 1'b0;
        // Released bus shows the inverse, so a stale value never passes for a held one
        host_address <= ~a;
        host_wdata <= ~d;
    endtask : access

    task automatic rd(input logic [7:0] a, input logic b, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'hxxxx;
        access(a, host_wdata, 1'b0, b);
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge clock);
            if (host_rvalid === 1'b1) begin
                ok = 1'b1;
                d = host_rdata;
            end
        end
    endtask : rd
endmodule : host_model

//--- tb/testbench.sv
`timescale 1ns/10ps

module testbench;
    logic        clock, rst_n, sof_ok, usb_bus_reset, suspend, host_powered_flag;
    logic [10:0] sof_frame;
    logic [2:0]  sof_microframe;
    logic        host_select, host_read, host_write, host_byte_mode, host_rvalid;
    logic [7:0]  host_address;
    logic [15:0] host_wdata, host_rdata, rv;
    logic        write_locked, force_high_speed, force_full_speed, chirp_disable, random_pattern_test;
    logic        drive_k_level, drive_j_level, quiescent_nak_test, test_mode_active, line_oe, line_dp, line_dm;
    logic        ok;
    logic [2:0]  got3;
    logic [2:0]  lines_exp [4] = '{3'b100, 3'b110, 3'b101, 3'b110};
    int          miscompares, checks_done;

    always #20 clock = ~clock;

    usb_misc_regs dut (.*);

    host_model host (.*);

    // ****************************************
    // Tasks
    // ****************************************
    task automatic finish_test;
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic b, input logic [15:0] exp, input string name);
        host.rd(a, b, rv, ok);
        if (!ok) begin
            miscompares++;
            finish_test();
        end else
            chk(name, exp, rv);
    endtask : rdc

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.access(a, d, 1'b1, 1'b0);
        @(negedge clock);
    endtask : wr

    task automatic bus_reset;
        @(posedge clock);
        usb_bus_reset <= 1'b1;
        @(posedge clock);
        usb_bus_reset <= 1'b0;
    endtask : bus_reset

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        {sof_ok, usb_bus_reset, suspend, host_powered_flag, sof_frame, sof_microframe} = '0;
        miscompares = 0;
        checks_done = 0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rdc(8'h78, 1'b0, 16'h0000, "scratch");
        rdc(8'h84, 1'b0, 16'h0000, "test");
        rdc(8'h7c, 1'b0, 16'h0000, "key");
        sof_ok <= 1'b1;
        sof_frame <= 11'h7ff;
        sof_microframe <= 3'h5;
        @(posedge clock);
        sof_ok <= 1'b0;
        rdc(8'h74, 1'b0, 16'h2fff, "frame");
        rdc(8'h74, 1'b1, 16'h00ff, "frame low");
        rdc(8'h74, 1'b1, 16'h002f, "frame high");
        wr(8'h74, 16'h0000);
        rdc(8'h74, 1'b0, 16'h2fff, "frame ro");
        wr(8'h78, 16'ha5c3);
        rdc(8'h78, 1'b0, 16'ha5c3, "scratch");
        bus_reset();
        rdc(8'h74, 1'b0, 16'h0000, "frame br");
        rdc(8'h78, 1'b0, 16'h0000, "scratch br");
        suspend <= 1'b1;
        wr(8'h78, 16'h1111);
        chk("locked", 16'h0001, {15'h0, write_locked});
        rdc(8'h78, 1'b0, 16'h0000, "locked write");
        wr(8'h7c, 16'h1234);
        chk("bad key", 16'h0001, {15'h0, write_locked});
        suspend <= 1'b0;
        wr(8'h7c, 16'haa37);
        chk("unlocked", 16'h0000, {15'h0, write_locked});
        wr(8'h78, 16'h5a5a);
        rdc(8'h78, 1'b0, 16'h5a5a, "after key");
        host_powered_flag <= 1'b1;
        suspend <= 1'b1;
        wr(8'h78, 16'h0f0f);
        rdc(8'h78, 1'b0, 16'h0f0f, "powered");
        chk("powered lock", 16'h0000, {15'h0, write_locked});
        suspend <= 1'b0;
        wr(8'h84, 16'h0064);
        rdc(8'h84, 1'b0, 16'h0004, "test rsvd");
        chk("k lines", 16'h0005, {13'h0, line_oe, line_dp, line_dm});
        wr(8'h84, 16'h0000);
        rdc(8'h84, 1'b0, 16'h0004, "test sticky");
        // One pattern bit at a time, each after a bus reset
        for (int i = 0; i < 4; i++) begin
            bus_reset();
            wr(8'h84, 16'h0001 << i);
            @(negedge clock);
            got3 = (i == 3) ? {line_oe, line_dp ^ line_dm, 1'b0} : {line_oe, line_dp, line_dm};
            chk("lines", {13'h0, lines_exp[i]}, {13'h0, got3});
            chk("pattern", 16'h0001 << i, {random_pattern_test, drive_k_level, drive_j_level, quiescent_nak_test});
        end
        wr(8'h84, 16'h0080);
        bus_reset();
        @(negedge clock);
        chk("hs kept", 16'h0016, {force_high_speed, force_full_speed, chirp_disable, test_mode_active,
            random_pattern_test});
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        chk("chip rst", 16'h0000, {force_high_speed, force_full_speed, test_mode_active, line_oe});
        wr(8'h84, 16'h0010);
        chk("fs", 16'h0003, {force_full_speed, chirp_disable});
        finish_test();
    end
endmodule : testbench
